// file: rtl/oscg_pkg.sv
// Constants shared by the octal serial card glue logic.
package oscg_pkg;

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned PORT_COUNT      = 8;
  localparam int unsigned WINDOW_BYTES    = 64;
  localparam int unsigned PORT_STRIDE     = 8;
  localparam int unsigned BASE_LSB        = 6;
  localparam int unsigned BASE_W          = 10;
  localparam int unsigned PORT_SEL_LSB    = 3;
  localparam int unsigned PORT_SEL_W      = 3;
  localparam int unsigned REG_OFS_W       = 3;
  localparam logic [2:0]  SUMMARY_OFS     = 3'h7;
  localparam logic [ADDR_W-1:0] DEFAULT_BASE = 16'h0280;

  // ---------------------------------------------------------------------
  // Interrupt routing
  // ---------------------------------------------------------------------
  localparam int unsigned IRQ_LINES       = 16;
  localparam int unsigned ROUTE_W         = 4;
  localparam logic [ROUTE_W-1:0] ROUTE_NONE = 4'h0;
  // Lines the card can reach: 2/9 (line 9), 3..7, 10, 11, 12, 15.
  localparam logic [IRQ_LINES-1:0] IRQ_LEGAL = 16'h9EF8;
  localparam logic [ROUTE_W-1:0] ROUTE_DEF_A = 4'h9;
  localparam logic [ROUTE_W-1:0] ROUTE_DEF_B = 4'h3;
  localparam logic [ROUTE_W-1:0] ROUTE_DEF_C = 4'h4;
  localparam logic [ROUTE_W-1:0] ROUTE_DEF_D = 4'h5;

  typedef enum logic [1:0] {
    OSCG_IRQ_NORMAL = 2'b00,
    OSCG_IRQ_SHARED = 2'b01,
    OSCG_IRQ_MASTER = 2'b11
  } oscg_irq_mode_t;

  // ---------------------------------------------------------------------
  // Reference clock prescaler
  // ---------------------------------------------------------------------
  localparam logic [1:0]  PRESCALE_LAST   = 2'h3;

endpackage : oscg_pkg

// file: rtl/oscg_irq_route.sv
// One port's interrupt steering onto the host interrupt lines.
`timescale 1ns/1ns
module oscg_irq_route
  import oscg_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 irq_in,
  input  wire logic [ROUTE_W-1:0]   route_sel,
  input  wire oscg_irq_mode_t       mode,
  output logic      [IRQ_LINES-1:0] line_out,
  output logic      [IRQ_LINES-1:0] line_oe,
  output logic      [IRQ_LINES-1:0] pull_oe
);

  logic [IRQ_LINES-1:0] hit;

  always_comb begin
    hit = '0;
    if (route_sel != ROUTE_NONE && IRQ_LEGAL[route_sel]) begin
      hit[route_sel] = 1'b1;
    end
  end

  // Shared mode only drives high while pending and releases otherwise, so
  // the line falls back through the single master pull-down.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      line_out <= '0;
      line_oe  <= '0;
      pull_oe  <= '0;
    end else begin
      if (mode == OSCG_IRQ_NORMAL) begin
        line_out <= hit & {IRQ_LINES{irq_in}};
        line_oe  <= hit;
      end else begin
        line_out <= hit & {IRQ_LINES{irq_in}};
        line_oe  <= hit & {IRQ_LINES{irq_in}};
      end
      pull_oe <= (mode == OSCG_IRQ_MASTER) ? hit : '0;
    end
  end

endmodule : oscg_irq_route

// file: rtl/oscg_card_glue.sv
// Glue logic of the eight-port serial card: decode, summary, IRQ, clock.
`timescale 1ns/1ns
module oscg_card_glue
  import oscg_pkg::*;
(
  input  wire logic                            mclk,
  input  wire logic                            arst_n,
  input  wire logic [ADDR_W-1:0]               io_addr,
  input  wire logic                            io_rd_n,
  input  wire logic                            io_wr_n,
  input  wire logic                            aen,
  output logic      [7:0]                      data_out,
  output logic                                 data_oe,
  input  wire logic [BASE_W-1:0]               base_switch_n,
  input  wire logic                            decode_source_select,
  input  wire logic [PORT_COUNT-1:0]           programmable_decode_port,
  input  wire logic                            programmable_decode_summary,
  input  wire logic                            uart_clock_prescale_select,
  input  wire oscg_irq_mode_t                  irq_drive_mode_low_group,
  input  wire oscg_irq_mode_t                  irq_drive_mode_high_group,
  input  wire logic [PORT_COUNT*ROUTE_W-1:0]   port_irq_route_select,
  input  wire logic [PORT_COUNT-1:0]           uart_irq,
  output logic      [PORT_COUNT-1:0]           uart_cs_n,
  output logic      [REG_OFS_W-1:0]            uart_reg_addr,
  output logic                                 uart_rd_n,
  output logic                                 uart_wr_n,
  output logic                                 uart_ref_clk,
  output logic      [IRQ_LINES-1:0]            irq_out,
  output logic      [IRQ_LINES-1:0]            irq_oe,
  output logic      [IRQ_LINES-1:0]            irq_pull_oe,
  input  wire logic [PORT_COUNT-1:0]           uart_td,
  input  wire logic [PORT_COUNT-1:0]           uart_rts,
  input  wire logic [PORT_COUNT-1:0]           uart_dtr,
  output logic      [PORT_COUNT-1:0]           port_td,
  output logic      [PORT_COUNT-1:0]           port_rts,
  output logic      [PORT_COUNT-1:0]           port_dtr,
  input  wire logic [PORT_COUNT-1:0]           port_rd,
  input  wire logic [PORT_COUNT-1:0]           port_cts,
  input  wire logic [PORT_COUNT-1:0]           port_dsr,
  input  wire logic [PORT_COUNT-1:0]           port_dcd,
  input  wire logic [PORT_COUNT-1:0]           port_ri,
  output logic      [PORT_COUNT-1:0]           uart_rd,
  output logic      [PORT_COUNT-1:0]           uart_cts,
  output logic      [PORT_COUNT-1:0]           uart_dsr,
  output logic      [PORT_COUNT-1:0]           uart_dcd,
  output logic      [PORT_COUNT-1:0]           uart_ri
);

  // -----------------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------------
  // Bus strobes and UART interrupts come from outside mclk; each passes
  // three flops and a change counts once the second and third agree.
  localparam int unsigned SYNC_W = PORT_COUNT + 2;

  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] s3_reg;
  logic [SYNC_W-1:0] filt_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg   <= {2'b11, {PORT_COUNT{1'b0}}};
      s2_reg   <= {2'b11, {PORT_COUNT{1'b0}}};
      s3_reg   <= {2'b11, {PORT_COUNT{1'b0}}};
      filt_reg <= {2'b11, {PORT_COUNT{1'b0}}};
    end else begin
      s1_reg <= {io_rd_n, io_wr_n, uart_irq};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < SYNC_W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  logic                  rd_act;
  logic                  wr_act;
  logic [PORT_COUNT-1:0] irq_live;

  assign rd_act   = !filt_reg[SYNC_W-1];
  assign wr_act   = !filt_reg[SYNC_W-2];
  assign irq_live = filt_reg[PORT_COUNT-1:0];

  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------
  logic [BASE_W-1:0]     base_bits;
  logic                  sw_hit;
  logic [PORT_COUNT-1:0] port_hit;
  logic                  sum_hit;
  logic [PORT_SEL_W-1:0] port_idx;

  // A closed switch pulls its input low, which reads as a 0 address bit.
  assign base_bits = base_switch_n;
  assign port_idx  = io_addr[PORT_SEL_LSB +: PORT_SEL_W];
  assign sw_hit    = !aen
                   && io_addr[ADDR_W-1:BASE_LSB] == base_bits;

  always_comb begin
    port_hit = '0;
    sum_hit  = 1'b0;
    if (decode_source_select) begin
      port_hit = aen ? '0 : programmable_decode_port;
      sum_hit  = !aen && programmable_decode_summary;
    end else if (sw_hit) begin
      if (io_addr[REG_OFS_W-1:0] == SUMMARY_OFS && rd_act) begin
        sum_hit = 1'b1;
      end else begin
        port_hit[port_idx] = 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // UART selects and summary read
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      uart_cs_n     <= '1;
      uart_reg_addr <= '0;
      uart_rd_n     <= 1'b1;
      uart_wr_n     <= 1'b1;
    end else begin
      uart_cs_n     <= (rd_act || wr_act) ? ~port_hit : '1;
      uart_reg_addr <= io_addr[REG_OFS_W-1:0];
      uart_rd_n     <= !(rd_act && port_hit != '0);
      uart_wr_n     <= !(wr_act && port_hit != '0);
    end
  end

  // Summary has no storage: it mirrors the live interrupt pins, so a bit
  // drops as soon as the UART source is serviced.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end else begin
      data_oe  <= rd_act && sum_hit;
      data_out <= (rd_act && sum_hit) ? irq_live : '0;
    end
  end

  // -----------------------------------------------------------------------
  // Interrupt steering
  // -----------------------------------------------------------------------
  logic [IRQ_LINES-1:0] r_out [PORT_COUNT];
  logic [IRQ_LINES-1:0] r_oe  [PORT_COUNT];
  logic [IRQ_LINES-1:0] r_pl  [PORT_COUNT];

  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_route
    oscg_irq_route u_route (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .irq_in    (irq_live[p]),
      .route_sel (port_irq_route_select[p*ROUTE_W +: ROUTE_W]),
      .mode      ((p < PORT_COUNT/2) ? irq_drive_mode_low_group
                                     : irq_drive_mode_high_group),
      .line_out  (r_out[p]),
      .line_oe   (r_oe[p]),
      .pull_oe   (r_pl[p])
    );
  end

  logic [IRQ_LINES-1:0] irq_out_next;
  logic [IRQ_LINES-1:0] irq_oe_next;
  logic [IRQ_LINES-1:0] irq_pull_oe_next;

  always_comb begin
    irq_out_next     = '0;
    irq_oe_next      = '0;
    irq_pull_oe_next = '0;
    for (int p = 0; p < PORT_COUNT; p++) begin
      irq_out_next     = irq_out_next | r_out[p];
      irq_oe_next      = irq_oe_next | r_oe[p];
      irq_pull_oe_next = irq_pull_oe_next | r_pl[p];
    end
  end

  // The merged lines are registered once more so that the enables seen on
  // the bus never glitch while several ports change in the same cycle.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_out     <= '0;
      irq_oe      <= '0;
      irq_pull_oe <= '0;
    end else begin
      irq_out     <= irq_out_next;
      irq_oe      <= irq_oe_next;
      irq_pull_oe <= irq_pull_oe_next;
    end
  end

  // -----------------------------------------------------------------------
  // Reference clock prescaler
  // -----------------------------------------------------------------------
  // Quarter rate keeps the usual PC rates; unity reaches four times them,
  // so software programs a quarter of the wanted rate.
  logic [1:0] pre_cnt_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_reg  <= '0;
      uart_ref_clk <= 1'b0;
    end else if (uart_clock_prescale_select) begin
      pre_cnt_reg  <= '0;
      uart_ref_clk <= !uart_ref_clk;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 2'h1;
      if (pre_cnt_reg == PRESCALE_LAST) begin
        uart_ref_clk <= !uart_ref_clk;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Modem line buffering
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      port_td  <= '1;
      port_rts <= '0;
      port_dtr <= '0;
      uart_rd  <= '1;
      uart_cts <= '0;
      uart_dsr <= '0;
      uart_dcd <= '0;
      uart_ri  <= '0;
    end else begin
      port_td  <= uart_td;
      port_rts <= uart_rts;
      port_dtr <= uart_dtr;
      uart_rd  <= port_rd;
      uart_cts <= port_cts;
      uart_dsr <= port_dsr;
      uart_dcd <= port_dcd;
      uart_ri  <= port_ri;
    end
  end

endmodule : oscg_card_glue

// file: tb/oscg_card_glue_sva.sv
// Port-level checks on the serial card glue logic.
`timescale 1ns/1ns
module oscg_card_glue_chk
  import oscg_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  arst_n,
  input wire logic [ADDR_W-1:0]     io_addr,
  input wire logic                  io_rd_n,
  input wire logic                  aen,
  input wire logic                  data_oe,
  input wire logic [BASE_W-1:0]     base_switch_n,
  input wire logic                  decode_source_select,
  input wire logic                  uart_clock_prescale_select,
  input wire logic [PORT_COUNT-1:0] uart_cs_n,
  input wire logic                  uart_ref_clk,
  input wire logic [IRQ_LINES-1:0]  irq_oe,
  input wire logic [IRQ_LINES-1:0]  irq_pull_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_cs_onehot: assert property ($onehot0(~uart_cs_n))
    else $error("more than one UART selected");
  a_cs_port_map: assert property ((!decode_source_select &&
    uart_cs_n != 8'hff) |-> uart_cs_n == ~(8'h01 << io_addr[5:3]))
    else $error("UART select does not match address");
  a_base_match: assert property ((!decode_source_select &&
    (data_oe || uart_cs_n != 8'hff)) |-> io_addr[15:6] == base_switch_n)
    else $error("selection outside the switch window");
  a_oe_needs_rd: assert property (data_oe |-> !($past(io_rd_n, 3) &&
    $past(io_rd_n, 4) && $past(io_rd_n, 5)))
    else $error("data bus driven without a read");
  a_aen_blocks: assert property (aen [*8] |->
    uart_cs_n == 8'hff && !data_oe)
    else $error("decode not blocked by aen");
  a_clk_quarter: assert property (disable iff (!arst_n ||
    uart_clock_prescale_select) (!uart_clock_prescale_select) [*8]
    ##0 $changed(uart_ref_clk) |-> ##1 $stable(uart_ref_clk) [*3]
    ##1 $changed(uart_ref_clk))
    else $error("quarter reference clock period wrong");
  a_clk_unity: assert property (uart_clock_prescale_select [*4] |->
    $changed(uart_ref_clk))
    else $error("unity reference clock not toggling");
  a_irq_legal: assert property (((irq_oe | irq_pull_oe) &
    ~IRQ_LEGAL) == 16'h0000)
    else $error("unreachable interrupt line driven");
  cover property (!data_oe ##1 data_oe);
  cover property ($rose(irq_pull_oe[15]));
  cover property (aen [*8]);
endmodule : oscg_card_glue_chk

bind oscg_card_glue oscg_card_glue_chk u_chk (.*);

// file: tb/oscg_host_model.sv
// Host processor model issuing I/O bus cycles to the card.
`timescale 1ns/1ns
module oscg_host_model
  import oscg_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic [7:0]            data_out,
  input  wire logic                  data_oe,
  input  wire logic [PORT_COUNT-1:0] uart_cs_n,
  input  wire logic [2:0]            uart_reg_addr,
  input  wire logic                  uart_rd_n,
  input  wire logic                  uart_wr_n,
  output logic      [ADDR_W-1:0]     io_addr,
  output logic                       io_rd_n,
  output logic                       io_wr_n,
  output logic                       aen
);
  logic [13:0] snap;
  logic [7:0]  dsnap;
  initial begin
    io_addr = 16'h0000;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    aen = 1'b0;
  end
  // Strobe held six cycles and address held through the drop, so the
  // three-flop filter always sees one clean pulse.
  task automatic io_cycle(input logic [ADDR_W-1:0] a, input logic wr,
                          input logic blk);
    @(posedge mclk);
    io_addr <= a;
    aen <= blk;
    if (wr) io_wr_n <= 1'b0;
    else io_rd_n <= 1'b0;
    repeat (6) @(posedge mclk);
    snap = {data_oe, uart_rd_n, uart_wr_n, uart_reg_addr, uart_cs_n};
    dsnap = data_out;
    io_rd_n <= 1'b1;
    io_wr_n <= 1'b1;
    repeat (6) @(posedge mclk);
    aen <= 1'b0;
    io_addr <= ~a;
  endtask : io_cycle
endmodule : oscg_host_model

// file: tb/tb_oscg_card_glue.sv
// Self-checking bench for the octal serial card glue.
`timescale 1ns/1ns
module tb_oscg_card_glue
  import oscg_pkg::*;
  ;
  logic mclk, arst_n, io_rd_n, io_wr_n, aen, data_oe, uart_ref_clk;
  logic decode_source_select, programmable_decode_summary;
  logic uart_clock_prescale_select, uart_rd_n, uart_wr_n;
  logic [ADDR_W-1:0] io_addr;
  logic [BASE_W-1:0] base_switch_n;
  logic [2:0] uart_reg_addr, p, o;
  logic [7:0] data_out, programmable_decode_port, uart_irq, uart_cs_n;
  logic [7:0] uart_td, uart_rts, uart_dtr, port_rd, port_cts, port_dsr;
  logic [7:0] port_dcd, port_ri, port_td, port_rts, port_dtr, uart_rd;
  logic [7:0] uart_cts, uart_dsr, uart_dcd, uart_ri;
  logic [31:0] port_irq_route_select;
  logic [15:0] irq_out, irq_oe, irq_pull_oe;
  logic [16:0] lfsr;
  oscg_irq_mode_t irq_drive_mode_low_group, irq_drive_mode_high_group;
  int err_total, samples_checked, cyc, tgl;

  oscg_card_glue DUT (.*);
  oscg_host_model u_host (.*);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr_next
  // Counts reference clock changes over sixteen cycles, sampled mid-cycle.
  task automatic ref_toggles(output int n);
    logic last;
    n = 0;
    @(negedge mclk);
    last = uart_ref_clk;
    repeat (16) begin
      @(negedge mclk);
      if (uart_ref_clk !== last) n++;
      last = uart_ref_clk;
    end
  endtask : ref_toggles
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    {arst_n, decode_source_select, programmable_decode_summary} = 3'b000;
    {uart_clock_prescale_select, programmable_decode_port} = 9'h000;
    {uart_irq, uart_td, uart_rts, uart_dtr, port_rd} = 40'h0;
    {port_cts, port_dsr, port_dcd, port_ri} = 32'h0;
    base_switch_n = 10'h00a;
    irq_drive_mode_low_group = OSCG_IRQ_NORMAL;
    irq_drive_mode_high_group = OSCG_IRQ_NORMAL;
    port_irq_route_select = 32'hba97_6543;
    lfsr = 17'd98773;
    cyc = 0;
    repeat (5) @(posedge mclk);
    check("reset select", {data_oe, uart_cs_n}, {1'b0, 8'hff});
    arst_n <= 1'b1;
    for (int n = 0; n < 16; n++) begin
      lfsr = lfsr_next(lfsr);
      if (n > 0) base_switch_n <= lfsr[16:7];
      uart_irq <= lfsr[7:0];
      {uart_td, uart_rts, uart_dtr} <= {3{lfsr[15:8]}};
      {port_rd, port_cts, port_dsr, port_dcd, port_ri} <= {5{lfsr[8:1]}};
      @(posedge mclk);
      p = lfsr[10:8];
      // Writes at offset 7 still reach the port's UART.
      o = (lfsr[13:11] == 3'h7 && !lfsr[14]) ? 3'h0 : lfsr[13:11];
      u_host.io_cycle({base_switch_n, p, o}, lfsr[14], 1'b0);
      check("port access", u_host.snap,
            {1'b0, lfsr[14], ~lfsr[14], o, ~(8'h01 << p)});
      u_host.io_cycle({base_switch_n, p, 3'h7}, 1'b0, 1'b0);
      check("summary", {u_host.snap[13], u_host.snap[7:0], u_host.dsnap},
            {1'b1, 8'hff, uart_irq});
      for (int k = 0; k < 8; k++)
        check("irq line", {irq_oe[port_irq_route_select[4*k +: 4]],
              irq_out[port_irq_route_select[4*k +: 4]]},
              {1'b1, uart_irq[k]});
      check("modem", {port_td, port_rts, port_dtr, uart_rd, uart_cts,
            uart_dsr, uart_dcd, uart_ri}, {uart_td, uart_rts, uart_dtr,
            port_rd, port_cts, port_dsr, port_dcd, port_ri});
      u_host.io_cycle({~base_switch_n, p, o}, 1'b0, lfsr[0]);
      check("outside", u_host.snap[13:11], 3'b011);
      u_host.io_cycle({base_switch_n, p, 3'h7}, 1'b0, 1'b1);
      check("aen", {u_host.snap[13], u_host.snap[7:0]}, 9'h0ff);
    end
    ref_toggles(tgl);
    check("quarter clock", tgl, 4);
    @(posedge mclk);
    uart_clock_prescale_select <= 1'b1;
    decode_source_select <= 1'b1;
    programmable_decode_summary <= 1'b1;
    u_host.io_cycle(16'h03f8, 1'b0, 1'b0);
    check("pal summary", {u_host.snap[13], u_host.dsnap},
          {1'b1, uart_irq});
    programmable_decode_summary <= 1'b0;
    programmable_decode_port <= 8'h20;
    u_host.io_cycle(16'h02f8, 1'b0, 1'b0);
    check("pal port", u_host.snap[7:0], 8'hdf);
    programmable_decode_port <= 8'h00;
    port_irq_route_select <= 32'hffff_ffff;
    irq_drive_mode_low_group <= OSCG_IRQ_MASTER;
    irq_drive_mode_high_group <= OSCG_IRQ_SHARED;
    repeat (8) @(posedge mclk);
    check("master pull", irq_pull_oe[15], 1'b1);
    irq_drive_mode_low_group <= OSCG_IRQ_SHARED;
    repeat (8) @(posedge mclk);
    check("no master", irq_pull_oe, 16'h0000);
    check("shared line", {irq_oe[15], irq_out[15]}, {2{|uart_irq}});
    ref_toggles(tgl);
    check("unity clock", tgl, 16);
    report_and_stop();
  end
endmodule : tb_oscg_card_glue
